// File: design/cfa_gain_offset_select.sv
// Purpose: Gain/offset pair registers and line 0 pattern selection
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes: Outputs update one core clock after a position change
//
// How it works
// - Index 7 holds signed offset for slot 3
// - Offset slot 3 read/write, resets to zero
// - Map fields give pair index per position
// - Position 3 uses map bits 7 to 6
// - Position 1 uses map bits 3 to 2
// - Gain registers hold 8-bit eighth-dB codes
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module cfa_gain_offset_select (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // AXI4-Lite write address
    input wire logic [cfa_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [cfa_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [cfa_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [cfa_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pixel timing pins
    input wire logic pix_clk_pin,
    input wire logic line_start_pin,
    // Amplifier controls
    output logic [cfa_pkg::REG_W-1:0] pga_gain,
    output logic [cfa_pkg::REG_W-1:0] pga_offset,
    output logic [cfa_pkg::SEL_W-1:0] active_pair
);
    step_if st ();

    logic [cfa_pkg::REG_W-1:0] regs [cfa_pkg::NUM_REGS];
    logic [cfa_pkg::ADDR_W-1:0] aw_addr;
    logic [cfa_pkg::DATA_W-1:0] w_data;
    logic [3:0] w_strb;

    // Decode: mapped word, storage or status
    function automatic logic is_store(input logic [cfa_pkg::ADDR_W-1:0] a);
        logic [cfa_pkg::IDX_W-1:0] idx;
        idx = a[cfa_pkg::ADDR_LSB +: cfa_pkg::IDX_W];
        return (a[cfa_pkg::ADDR_W-1:cfa_pkg::ADDR_LSB+cfa_pkg::IDX_W] == '0)
            && (idx <= cfa_pkg::IDX_MAP0);
    endfunction : is_store

    function automatic logic is_status(input logic [cfa_pkg::ADDR_W-1:0] a);
        return (a[cfa_pkg::ADDR_W-1:cfa_pkg::ADDR_LSB+cfa_pkg::IDX_W] == '0)
            && (a[cfa_pkg::ADDR_LSB +: cfa_pkg::IDX_W] == cfa_pkg::IDX_STATUS);
    endfunction : is_status

    // Write path
    wire wr_commit = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire [cfa_pkg::IDX_W-1:0] wr_idx = aw_addr[cfa_pkg::ADDR_LSB +: cfa_pkg::IDX_W];
    wire wr_ok = is_store(aw_addr);
    wire wr_en = wr_commit && wr_ok && w_strb[0];

    // Read path
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [cfa_pkg::IDX_W-1:0] rd_idx = s_axi_araddr[cfa_pkg::ADDR_LSB +: cfa_pkg::IDX_W];
    wire rd_store = is_store(s_axi_araddr);
    wire rd_status = is_status(s_axi_araddr);
    wire [cfa_pkg::REG_W-1:0] status_word = {4'h0, st.sel, st.pos};
    wire [cfa_pkg::REG_W-1:0] rd_byte = rd_store ? regs[rd_idx] : status_word;

    // Selected pair for the current position
    wire [cfa_pkg::IDX_W-1:0] gain_idx = cfa_pkg::IDX_GAIN0 + {2'h0, st.sel};
    wire [cfa_pkg::IDX_W-1:0] offs_idx = cfa_pkg::IDX_OFFSET0 + {2'h0, st.sel};

    pixel_sync u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .pix_clk_pin(pix_clk_pin),
        .line_start_pin(line_start_pin),
        .ev(st.sync)
    );

    position_stepper u_step (
        .core_clk(core_clk),
        .rstn(rstn),
        .line0_map(regs[cfa_pkg::IDX_MAP0]),
        .st(st.stepper)
    );

    // Write channel handshakes, address and data in either order
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cfa_pkg::RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_commit) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? cfa_pkg::RESP_OKAY : cfa_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Only byte lane 0 carries register data
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < cfa_pkg::NUM_REGS; i++) begin
                regs[i] <= cfa_pkg::REG_RESET;
            end
        end else if (wr_en) begin
            regs[wr_idx] <= w_data[cfa_pkg::REG_W-1:0];
        end
    end

    // Read channel, answer one cycle after the address is taken
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= cfa_pkg::RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= (rd_store || rd_status) ? {24'h0, rd_byte} : '0;
                s_axi_rresp <= (rd_store || rd_status) ? cfa_pkg::RESP_OKAY
                                                       : cfa_pkg::RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Registered; a software write to the selected pair reaches the amplifier one core clock later, even mid-pixel
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pga_gain <= cfa_pkg::REG_RESET;
            pga_offset <= cfa_pkg::REG_RESET;
            active_pair <= '0;
        end else begin
            pga_gain <= regs[gain_idx];
            pga_offset <= regs[offs_idx];
            active_pair <= st.sel;
        end
    end

    // Checks
    localparam logic [cfa_pkg::POS_W-1:0] POS_TWO = 2'h2;

    a_offset3_reset: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(!rstn) |-> regs[cfa_pkg::IDX_OFFSET3] == cfa_pkg::REG_RESET)
        else $error("offset slot 3 not zero after reset");

    a_offset3_write: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_en && wr_idx == cfa_pkg::IDX_OFFSET3
        |=> regs[cfa_pkg::IDX_OFFSET3] == $past(w_data[7:0]))
        else $error("offset slot 3 write lost");

    a_offset3_read: assert property (@(posedge core_clk) disable iff (!rstn)
        ar_take && rd_store && rd_idx == cfa_pkg::IDX_OFFSET3
        |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(regs[cfa_pkg::IDX_OFFSET3])})
        else $error("offset slot 3 readback wrong");

    // Past value, so a slot 3 write in the same cycle cannot trip it
    a_offset_applied: assert property (@(posedge core_clk) disable iff (!rstn)
        st.sel == 2'h3 && $stable(st.sel)
        |=> pga_offset == $past(regs[cfa_pkg::IDX_OFFSET3]))
        else $error("slot 3 offset not applied");

    a_pos3_pair: assert property (@(posedge core_clk) disable iff (!rstn)
        st.pos == cfa_pkg::POS_THREE
        |=> active_pair == $past(regs[cfa_pkg::IDX_MAP0][7:6]))
        else $error("position 3 pair wrong");

    a_pos1_pair: assert property (@(posedge core_clk) disable iff (!rstn)
        st.pos == cfa_pkg::POS_ONE
        |=> active_pair == $past(regs[cfa_pkg::IDX_MAP0][3:2]))
        else $error("position 1 pair wrong");

    a_pos2_pair: assert property (@(posedge core_clk) disable iff (!rstn)
        st.pos == POS_TWO
        |=> active_pair == $past(regs[cfa_pkg::IDX_MAP0][5:4]))
        else $error("position 2 pair wrong");

    a_pos0_pair: assert property (@(posedge core_clk) disable iff (!rstn)
        st.pos == cfa_pkg::POS_FIRST
        |=> active_pair == $past(regs[cfa_pkg::IDX_MAP0][1:0]))
        else $error("position 0 pair wrong");

    a_gain_follow: assert property (@(posedge core_clk) disable iff (!rstn)
        st.step ##1 (!st.step)[*2]
        |-> pga_gain == regs[cfa_pkg::IDX_GAIN0 + {2'h0, active_pair}])
        else $error("gain does not follow pair");

    a_offset_follow: assert property (@(posedge core_clk) disable iff (!rstn)
        st.step ##1 (!st.step)[*2]
        |-> pga_offset == regs[cfa_pkg::IDX_OFFSET0 + {2'h0, active_pair}])
        else $error("offset does not follow pair");

    a_step_advance: assert property (@(posedge core_clk) disable iff (!rstn)
        st.step && !st.line_start |=> st.pos == $past(st.pos) + cfa_pkg::POS_ONE)
        else $error("position did not advance");

    a_line_restart: assert property (@(posedge core_clk) disable iff (!rstn)
        st.step && st.line_start |=> st.pos == cfa_pkg::POS_FIRST)
        else $error("line start did not restart");

    a_pos_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        !st.step |=> $stable(st.pos))
        else $error("position moved without step");

    a_step_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        st.step |=> !st.step)
        else $error("step pulse longer than one cycle");

    a_output_reset: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(!rstn) |-> pga_gain == cfa_pkg::REG_RESET && pga_offset == cfa_pkg::REG_RESET)
        else $error("amplifier controls not cleared by reset");

    a_map_reset: assert property (@(posedge core_clk) disable iff (!rstn)
        $past(!rstn) |-> regs[cfa_pkg::IDX_MAP0] == cfa_pkg::REG_RESET)
        else $error("pattern map not zero after reset");

    a_status_read: assert property (@(posedge core_clk) disable iff (!rstn)
        ar_take && rd_status
        |=> s_axi_rdata == {24'h0, 4'h0, $past(st.sel), $past(st.pos)})
        else $error("status word wrong");

    // Bus side: answers, refusals and release
    a_write_answer: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_commit |=> s_axi_bvalid)
        else $error("write not answered");

    a_commit_once: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_commit |=> !wr_commit)
        else $error("write committed twice");

    a_write_error: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_commit && !wr_ok
        |=> s_axi_bresp == cfa_pkg::RESP_SLVERR && $stable(regs[cfa_pkg::IDX_OFFSET3]))
        else $error("unmapped write not refused");

    a_lane_off: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_commit && wr_ok && !w_strb[0]
        |=> s_axi_bresp == cfa_pkg::RESP_OKAY && $stable(regs[wr_idx]))
        else $error("write without lane 0 changed a register");

    a_write_block: assert property (@(posedge core_clk) disable iff (!rstn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");

    a_write_release: assert property (@(posedge core_clk) disable iff (!rstn)
        s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not released");

    a_read_answer: assert property (@(posedge core_clk) disable iff (!rstn)
        ar_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");

    a_read_error: assert property (@(posedge core_clk) disable iff (!rstn)
        ar_take && !rd_store && !rd_status
        |=> s_axi_rresp == cfa_pkg::RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read not refused");

    a_read_upper: assert property (@(posedge core_clk) disable iff (!rstn)
        s_axi_rvalid |-> s_axi_rdata[cfa_pkg::DATA_W-1:cfa_pkg::REG_W] == '0)
        else $error("read data upper bits not zero");

    a_read_block: assert property (@(posedge core_clk) disable iff (!rstn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");

    a_read_release: assert property (@(posedge core_clk) disable iff (!rstn)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not released");

    c_full_pattern: cover property (@(posedge core_clk) disable iff (!rstn)
        st.pos == cfa_pkg::POS_THREE && st.step ##1 st.pos == cfa_pkg::POS_FIRST);
    c_offset3_write: cover property (@(posedge core_clk) disable iff (!rstn)
        wr_en && wr_idx == cfa_pkg::IDX_OFFSET3);
    c_map_write: cover property (@(posedge core_clk) disable iff (!rstn)
        wr_en && wr_idx == cfa_pkg::IDX_MAP0);
    c_bad_read: cover property (@(posedge core_clk) disable iff (!rstn)
        ar_take && !rd_store && !rd_status);
    c_status_read: cover property (@(posedge core_clk) disable iff (!rstn)
        ar_take && rd_status);
endmodule : cfa_gain_offset_select

// File: inc/cfa_pkg.sv
// Purpose: Shared constants and helpers for the pattern gain/offset slice
// Assumes: Register index times four gives the AXI4-Lite byte address
// Notes: Gain codes step by one eighth of a decibel, offsets are signed
package cfa_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = 4;
    localparam int ADDR_LSB = 2;
    localparam int POS_W = 2;
    localparam int SEL_W = 2;
    localparam int NUM_PAIRS = 4;

    // Register indices, byte address is index shifted by ADDR_LSB
    localparam logic [IDX_W-1:0] IDX_GAIN0 = 4'h0;
    localparam logic [IDX_W-1:0] IDX_OFFSET0 = 4'h4;
    localparam logic [IDX_W-1:0] IDX_OFFSET3 = 4'h7;
    localparam logic [IDX_W-1:0] IDX_MAP0 = 4'h8;
    localparam logic [IDX_W-1:0] IDX_STATUS = 4'hf;
    localparam int NUM_REGS = 9;

    localparam logic [REG_W-1:0] REG_RESET = 8'h00;
    localparam logic [POS_W-1:0] POS_FIRST = 2'h0;
    localparam logic [POS_W-1:0] POS_ONE = 2'h1;
    localparam logic [POS_W-1:0] POS_THREE = 2'h3;

    // Status word layout
    localparam int STAT_POS_LSB = 0;
    localparam int STAT_SEL_LSB = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Two-bit pair select for one pattern position
    function automatic logic [SEL_W-1:0] pair_field(input logic [REG_W-1:0] map,
                                                    input logic [POS_W-1:0] pos);
        return map[{pos, 1'b0} +: SEL_W];
    endfunction : pair_field
endpackage : cfa_pkg

// File: inc/step_if.sv
// Purpose: Carries pixel stepping events and the current pair selection
// Assumes: All signals on core_clk
// Notes: step is a one-cycle pulse per pixel clock rising edge
`timescale 1ns/1ps
interface step_if;
    logic step;
    logic line_start;
    logic [cfa_pkg::POS_W-1:0] pos;
    logic [cfa_pkg::SEL_W-1:0] sel;

    modport sync (output step, output line_start);
    modport stepper (input step, input line_start, output pos, output sel);
    modport core (input step, input line_start, input pos, input sel);
endinterface : step_if

// File: design/pixel_sync.sv
// Purpose: Brings the pixel clock and line start pins into core_clk
// Assumes: Pixel clock slower than half of core_clk
// Notes: Edge taken between second and third stage, never the first
`timescale 1ns/1ps
module pixel_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Pins
    input wire logic pix_clk_pin,
    input wire logic line_start_pin,
    // Events
    step_if.sync ev
);
    logic [2:0] pix_pipe;
    logic [1:0] line_pipe;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pix_pipe <= 3'h0;
            line_pipe <= 2'h0;
        end else begin
            pix_pipe <= {pix_pipe[1:0], pix_clk_pin};
            line_pipe <= {line_pipe[0], line_start_pin};
        end
    end

    assign ev.step = pix_pipe[1] & ~pix_pipe[2];
    assign ev.line_start = line_pipe[1];
endmodule : pixel_sync

// File: design/position_stepper.sv
// Purpose: Tracks the pixel position within pattern line 0
// Assumes: Line 0 pattern repeats every four positions
// Notes: Line start on a step restarts at position 0
`timescale 1ns/1ps
module position_stepper (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Pattern map
    input wire logic [cfa_pkg::REG_W-1:0] line0_map,
    // Events and selection
    step_if.stepper st
);
    logic [cfa_pkg::POS_W-1:0] pos;
    logic [cfa_pkg::POS_W-1:0] next_pos;

    assign next_pos = st.line_start ? cfa_pkg::POS_FIRST : pos + cfa_pkg::POS_ONE;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pos <= cfa_pkg::POS_FIRST;
        end else if (st.step) begin
            pos <= next_pos;
        end
    end

    assign st.pos = pos;
    assign st.sel = cfa_pkg::pair_field(line0_map, pos);
endmodule : position_stepper

// File: sim/test_cfa_gain_offset_select.sv
// Purpose: Self-checking bench for the pattern gain/offset slice
// Assumes: Registers reached over AXI4-Lite, byte address is index times four
// Notes: Pixel clock pulses are 4 core clocks high and 4 low, well above the sync floor
`timescale 1ns/1ps
module test_cfa_gain_offset_select;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [3:0] wr_strb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic pix_clk_pin = 1'b0;
    logic line_start_pin = 1'b0;
    logic [7:0] pga_gain;
    logic [7:0] pga_offset;
    logic [1:0] active_pair;
    int error_cnt = 0;
    int total_checks = 0;

    cfa_gain_offset_select dut_u (.core_clk(core_clk), .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pix_clk_pin(pix_clk_pin),
        .line_start_pin(line_start_pin), .pga_gain(pga_gain), .pga_offset(pga_offset),
        .active_pair(active_pair));

    always #2 core_clk = ~core_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic axi_write(input logic [31:0] addr, input logic [31:0] data,
                             input logic [1:0] exp_resp);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done = 0;
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wstrb <= wr_strb;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge core_clk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, exp_resp});
        s_axi_bready <= 1'b0;
        // Idle edge, so a following call raises bready in a later step
        @(posedge core_clk);
    endtask : axi_write

    task automatic axi_read(input logic [31:0] addr, input logic [31:0] exp_data,
                            input logic [1:0] exp_resp);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, exp_data);
        chk({30'h0, s_axi_rresp}, {30'h0, exp_resp});
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask : axi_read

    function automatic logic [31:0] byte_addr(input logic [3:0] idx);
        return {26'h0, idx, 2'b00};
    endfunction : byte_addr

    // One pixel clock period, then the selected pair is compared
    task automatic pixel_step(input logic restart, input logic [1:0] pair);
        line_start_pin <= restart;
        pix_clk_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        pix_clk_pin <= 1'b0;
        line_start_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk({30'h0, active_pair}, {30'h0, pair});
        chk({24'h0, pga_gain}, {24'h0, 8'h40 | {6'h0, pair}});
        chk({24'h0, pga_offset}, {24'h0, 8'hf0 | {6'h0, pair}});
    endtask : pixel_step

    task automatic test_reset_values;
        chk({14'h0, pga_gain, pga_offset, active_pair}, 32'h0);
        axi_read(byte_addr(cfa_pkg::IDX_OFFSET3), 32'h0, cfa_pkg::RESP_OKAY);
        axi_read(byte_addr(cfa_pkg::IDX_MAP0), 32'h0, cfa_pkg::RESP_OKAY);
    endtask : test_reset_values

    task automatic test_offset_slot3;
        axi_write(byte_addr(cfa_pkg::IDX_OFFSET3), 32'h80, cfa_pkg::RESP_OKAY);
        axi_read(byte_addr(cfa_pkg::IDX_OFFSET3), 32'h80, cfa_pkg::RESP_OKAY);
        axi_write(byte_addr(cfa_pkg::IDX_OFFSET3), 32'hffffff7f, cfa_pkg::RESP_OKAY);
        axi_read(byte_addr(cfa_pkg::IDX_OFFSET3), 32'h7f, cfa_pkg::RESP_OKAY);
        // Unmapped place must neither store nor alias onto slot 3
        axi_write(32'h40, 32'h55, cfa_pkg::RESP_SLVERR);
        axi_read(32'h40, 32'h0, cfa_pkg::RESP_SLVERR);
        // Lane 0 off is accepted but stores nothing; status is read only
        wr_strb = 4'h0;
        axi_write(byte_addr(cfa_pkg::IDX_OFFSET3), 32'h11, cfa_pkg::RESP_OKAY);
        wr_strb = 4'hf;
        axi_write(byte_addr(cfa_pkg::IDX_STATUS), 32'h11, cfa_pkg::RESP_SLVERR);
        axi_read(byte_addr(cfa_pkg::IDX_OFFSET3), 32'h7f, cfa_pkg::RESP_OKAY);
    endtask : test_offset_slot3

    // Pair s gets gain 0x40+s and offset 0xf0+s, so every pair is distinct
    task automatic test_pattern(input logic [7:0] map);
        axi_write(byte_addr(cfa_pkg::IDX_MAP0), {24'h0, map}, cfa_pkg::RESP_OKAY);
        axi_read(byte_addr(cfa_pkg::IDX_MAP0), {24'h0, map}, cfa_pkg::RESP_OKAY);
        pixel_step(1'b1, map[1:0]);
        pixel_step(1'b0, map[3:2]);
        pixel_step(1'b0, map[5:4]);
        pixel_step(1'b0, map[7:6]);
        pixel_step(1'b0, map[1:0]);
        axi_read(byte_addr(cfa_pkg::IDX_STATUS), {28'h0, map[1:0], cfa_pkg::POS_FIRST},
                 cfa_pkg::RESP_OKAY);
    endtask : test_pattern

    // Reset in mid-run must clear what the earlier scenarios wrote
    task automatic test_reset_again;
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        test_reset_values();
    endtask : test_reset_again

    task automatic complete_run;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        test_reset_values();
        test_offset_slot3();
        for (int s = 0; s < 4; s++) begin
            axi_write(byte_addr(cfa_pkg::IDX_GAIN0 + 4'(s)), 32'h40 + 32'(s),
                      cfa_pkg::RESP_OKAY);
            axi_write(byte_addr(cfa_pkg::IDX_OFFSET0 + 4'(s)), 32'hf0 + 32'(s),
                      cfa_pkg::RESP_OKAY);
        end
        axi_read(byte_addr(cfa_pkg::IDX_GAIN0 + 4'h3), 32'h43, cfa_pkg::RESP_OKAY);
        test_pattern(8'h1b);
        test_pattern(8'he4);
        test_pattern(8'h9c);
        test_reset_again();
        complete_run();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        complete_run();
    end
endmodule : test_cfa_gain_offset_select
